// *** tsb_consts.vh ***
// Constants for the extended tape status byte bank.
// Included by every design file of the bank; definitions only.
`ifndef TSB_CONSTS_VH
`define TSB_CONSTS_VH

// ****************************************************************
// Block sizes and byte offsets (index within a read-out block)
// ****************************************************************
`define TSB_FULL_LEN       5'd17
`define TSB_COND_LEN       5'd9
`define TSB_OFS_WR_ERR     5'd0
`define TSB_OFS_RD_ERR     5'd1
`define TSB_OFS_DIAG_LOG   5'd2
`define TSB_OFS_DIAG_FAIL  5'd3
`define TSB_OFS_TRK_ERR    5'd4
`define TSB_OFS_DETAIL     5'd5
`define TSB_OFS_MISC_FIRST 5'd6
`define TSB_OFS_MISC_LAST  5'd13
`define TSB_OFS_DENSITY    5'd14
`define TSB_OFS_CONFIG     5'd15
`define TSB_OFS_F17        5'd16
`define TSB_OFS_COND_LAST  5'd8

// ****************************************************************
// Density codes
// ****************************************************************
`define TSB_DENS_NRZ       2'h0
`define TSB_DENS_PE        2'h1
`define TSB_DENS_GCR       2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define TSB_DIAG_IF_MSB    4
`define TSB_DIAG_PNL_MSB   6
`define TSB_DET_NRZ        7
`define TSB_DET_IDENT      6
`define TSB_DET_CORR       5
`define TSB_DET_VPE_GP     4
`define TSB_DET_SKEW       3
`define TSB_DET_MTE        2
`define TSB_DET_FPOST      1
`define TSB_DET_FPRE       0
`define TSB_DET_LRC        2
`define TSB_DET_CRC        1
`define TSB_DET_VPE_NRZ    0

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define TSB_BYTE_RST       8'h00
`define TSB_BYTE_MAX       8'hff
`define TSB_SKEW_LIMIT     4'h8
`define TSB_GCR_FIX_TRK    4'h2
`define TSB_PE_FIX_TRK     4'h1

`endif

// *** tsb_sat_cnt.v ***
// Saturating byte-wide error counter with synchronous clear.
// Assumes clk_sys domain only; clear and increment are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tsb_consts.vh"

module tsb_sat_cnt #(
    parameter W = 8
) (
    input  wire         clk_sys,  // System clock
    input  wire         sys_rst,  // Synchronous reset, high
    input  wire         clr,      // Clear count
    input  wire         inc,      // Count one event
    output reg  [W-1:0] cnt_q     // Current count
);
    // ****************************************************************
    // Counter
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst || clr) begin
            cnt_q <= {W{1'b0}};
        end else if (inc && (cnt_q != {W{1'b1}})) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // tsb_sat_cnt

`default_nettype wire

// *** tsb_detail.v ***
// Hard-error detail byte whose bit meanings follow the active density.
// Assumes event inputs are one-cycle pulses in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
`include "tsb_consts.vh"

module tsb_detail (
    input  wire       clk_sys,        // System clock
    input  wire       sys_rst,        // Synchronous reset, high
    input  wire       clr,            // Clear sticky flags
    input  wire [1:0] density,        // Active density code
    input  wire       ident_evt,      // Ident, alignment burst or ident seen
    input  wire       rd_fwd_fmt,     // Forward read expecting formatted block
    input  wire       corr_evt,       // Error was corrected
    input  wire       vpe_evt,        // Vertical parity error
    input  wire       single_drop,    // Single-track dropout present
    input  wire [3:0] skew_bits,      // Measured track-to-track skew
    input  wire       skew_evt,       // Skew measurement valid
    input  wire       drop_evt,       // Track dropout event
    input  wire [3:0] drop_trk_cnt,   // Tracks dropped
    input  wire       fpost_evt,      // False postamble
    input  wire       fpre_evt,       // False preamble
    input  wire       lrc_evt,        // Longitudinal check error
    input  wire       crc_evt,        // Cyclic check error
    output reg  [7:0] detail_q        // Detail byte
);
    reg  [7:0] set_d;
    wire       nrz_w = (density == `TSB_DENS_NRZ);
    wire       pe_w  = (density == `TSB_DENS_PE);

    // ****************************************************************
    // Event decode per density
    // ****************************************************************
    always @* begin
        set_d = 8'h00;
        if (nrz_w) begin
            set_d[`TSB_DET_LRC]     = lrc_evt;
            set_d[`TSB_DET_CRC]     = crc_evt;
            set_d[`TSB_DET_VPE_NRZ] = vpe_evt;
        end else begin
            set_d[`TSB_DET_IDENT]  = ident_evt && rd_fwd_fmt;
            set_d[`TSB_DET_CORR]   = corr_evt;
            set_d[`TSB_DET_VPE_GP] = vpe_evt && !single_drop;
            set_d[`TSB_DET_SKEW]   = skew_evt && (skew_bits > `TSB_SKEW_LIMIT);
            set_d[`TSB_DET_MTE]    = drop_evt && (drop_trk_cnt > (pe_w ? `TSB_PE_FIX_TRK : `TSB_GCR_FIX_TRK));
            set_d[`TSB_DET_FPOST]  = fpost_evt || (pe_w && fpre_evt);
            set_d[`TSB_DET_FPRE]   = fpre_evt;
        end
    end

    // ****************************************************************
    // Sticky flags; a set in the clearing cycle wins
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            detail_q <= `TSB_BYTE_RST;
        end else begin
            detail_q[6:0]          <= (clr ? 7'h00 : detail_q[6:0]) | set_d[6:0];
            detail_q[`TSB_DET_NRZ] <= nrz_w;
        end
    end
endmodule // tsb_detail

`default_nettype wire

// *** tsb_status_bank.v ***
// Extended status byte bank: seventeen full and nine condensed bytes.
// Assumes one clk_sys domain; all inputs synchronous; commands are pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tsb_consts.vh"

// Behaviour
// - Seventeen full bytes, nine condensed bytes
// - Access commands return the bytes in order
// - Power-up clears; density, config, condensed last loaded
// - Motion command clears bytes five to twelve
// - Clearing diagnostic clears; density bytes from selection
// - Count on-line write errors in byte one
// - Count on-line hard read errors, byte two
// - Log program number, five or seven bits
// - Without skip, keep failed program and code
// - On-line failure without skip stores code; zero means none
// - Off-line with skip, byte four counts failures
// - On-line track error flags, bit per track
// - Detail bit seven shows NRZ density active
// - Detail bit six: ident found, forward read
// - Corrected error flag, no hard error line
// - Vertical parity without single-track dropout
// - Skew above eight bits sets bit three
// - Multi-track dropout; GCR fixes two tracks
// - False postamble/preamble; PE preamble sets both
// - NRZ: bits LRC, CRC, vertical parity
module tsb_status_bank (
    input  wire       clk_sys,           // System clock, 50 MHz
    input  wire       sys_rst,           // Synchronous power-up reset, high
    input  wire [7:0] cfg_density_byte,  // Stored configuration density byte
    input  wire [7:0] cfg_config_byte,   // Stored second configuration byte
    input  wire [1:0] density_sel,       // Currently selected density
    input  wire       online,            // Unit is on-line
    input  wire       failure_skip,      // Failure-skip option active
    input  wire       cmd_full_status,   // Full-status access command
    input  wire       cmd_cond_status,   // Condensed-status access command
    input  wire       cmd_diag_results,  // Diagnostic results request
    input  wire       motion_accept,     // Tape motion command accepted
    input  wire       diag_clear,        // Status-clearing diagnostic runs
    input  wire       wr_err_evt,        // Write error, hard or corrected
    input  wire       rd_hard_evt,       // Hard read error
    input  wire       diag_call,         // Diagnostic program called
    input  wire       diag_from_panel,   // Call came from control panel
    input  wire [6:0] diag_num,          // Called program number
    input  wire       diag_fail,         // Diagnostic failed
    input  wire [7:0] diag_code,         // Failure code
    input  wire       trk_err_evt,       // Track error detected
    input  wire [7:0] trk_err_mask,      // Tracks in error
    input  wire       ident_evt,         // Ident or alignment_burst found
    input  wire       rd_fwd_fmt,        // Forward read expects formatted block
    input  wire       corr_evt,          // Corrected read error
    input  wire       vpe_evt,           // Vertical parity error
    input  wire       single_drop,       // Single-track dropout present
    input  wire [3:0] skew_bits,         // Measured skew
    input  wire       skew_evt,          // Skew measurement valid
    input  wire       drop_evt,          // Dropout event
    input  wire [3:0] drop_trk_cnt,      // Tracks dropped
    input  wire       fpost_evt,         // False postamble
    input  wire       fpre_evt,          // False preamble
    input  wire       lrc_evt,           // Longitudinal check error
    input  wire       crc_evt,           // Cyclic check error
    input  wire       misc_wr,           // Write strobe for other status bytes
    input  wire [4:0] misc_idx,          // Byte index of that write
    input  wire [7:0] misc_data,         // Data of that write
    output reg        rd_valid_q,        // Status byte on rd_data_q
    output reg  [7:0] rd_data_q,         // Status byte
    output reg        rd_last_q,         // Last byte of block
    output reg        busy_q,            // Read-out in progress
    output reg        hard_error_line_q  // Hard error interface line pulse
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg        state_q;
    reg        cond_q;
    reg  [4:0] idx_q;
    reg  [4:0] len_q;
    reg        load_q;
    reg  [7:0] diag_program_log_q;
    reg  [7:0] diag_failure_code_q;
    reg  [7:0] track_error_flags_q;
    reg  [7:0] density_status_byte_q;
    reg  [7:0] config_status_byte_q;
    reg  [7:0] condensed_last_byte_q;
    reg  [7:0] f17_q;
    reg  [7:0] misc_q [6:13];
    reg  [7:0] byte_d;
    wire [7:0] write_error_count;
    wire [7:0] read_hard_error_count;
    wire [7:0] hard_error_detail;
    wire       clr_all = diag_clear;
    wire       clr_mot = motion_accept || diag_clear;
    wire       take    = (state_q == ST_IDLE) && !load_q &&
                         (cmd_full_status || cmd_cond_status || cmd_diag_results);
    integer    i;

    function [7:0] sat_inc;
        input [7:0] v;
        begin
            sat_inc = (v == `TSB_BYTE_MAX) ? v : v + 8'h01;
        end
    endfunction

    // ****************************************************************
    // Error counters and detail byte
    // ****************************************************************
    tsb_sat_cnt #(
        .W (8)
    ) u_wr_cnt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clr     (clr_all),
        .inc     (wr_err_evt && online),
        .cnt_q   (write_error_count)
    );

    tsb_sat_cnt #(
        .W (8)
    ) u_rd_cnt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clr     (clr_all),
        .inc     (rd_hard_evt && online),
        .cnt_q   (read_hard_error_count)
    );

    tsb_detail u_detail (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .clr          (clr_mot),
        .density      (density_sel),
        .ident_evt    (ident_evt),
        .rd_fwd_fmt   (rd_fwd_fmt),
        .corr_evt     (corr_evt),
        .vpe_evt      (vpe_evt),
        .single_drop  (single_drop),
        .skew_bits    (skew_bits),
        .skew_evt     (skew_evt),
        .drop_evt     (drop_evt),
        .drop_trk_cnt (drop_trk_cnt),
        .fpost_evt    (fpost_evt),
        .fpre_evt     (fpre_evt),
        .lrc_evt      (lrc_evt),
        .crc_evt      (crc_evt),
        .detail_q     (hard_error_detail)
    );

    // ****************************************************************
    // Hard error line: hard read errors only, corrected ones excluded
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hard_error_line_q <= 1'b0;
        end else begin
            hard_error_line_q <= rd_hard_evt;
        end
    end

    // ****************************************************************
    // Diagnostic log and failure byte
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            diag_program_log_q  <= `TSB_BYTE_RST;
            diag_failure_code_q <= `TSB_BYTE_RST;
        end else begin
            if (diag_call) begin
                if (diag_from_panel) begin
                    diag_program_log_q <= {1'b0, diag_num[`TSB_DIAG_PNL_MSB:0]};
                end else begin
                    diag_program_log_q <= {3'h0, diag_num[`TSB_DIAG_IF_MSB:0]};
                end
            end else if (clr_all) begin
                diag_program_log_q <= `TSB_BYTE_RST;
            end
            if (diag_fail && failure_skip && !online) begin
                diag_failure_code_q <= sat_inc(clr_all ? `TSB_BYTE_RST : diag_failure_code_q);
            end else if (diag_fail && !failure_skip) begin
                diag_failure_code_q <= diag_code;
            end else if (diag_call && !failure_skip) begin
                diag_failure_code_q <= `TSB_BYTE_RST;
            end else if (clr_all) begin
                diag_failure_code_q <= `TSB_BYTE_RST;
            end
        end
    end

    // ****************************************************************
    // Track flags, bytes seven to fourteen and byte seventeen
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            track_error_flags_q <= `TSB_BYTE_RST;
            f17_q               <= `TSB_BYTE_RST;
            for (i = `TSB_OFS_MISC_FIRST; i <= `TSB_OFS_MISC_LAST; i = i + 1) begin
                misc_q[i] <= `TSB_BYTE_RST;
            end
        end else begin
            track_error_flags_q <= (clr_mot ? 8'h00 : track_error_flags_q) |
                                   ((trk_err_evt && online) ? trk_err_mask : 8'h00);
            for (i = `TSB_OFS_MISC_FIRST; i <= `TSB_OFS_MISC_LAST; i = i + 1) begin
                if (misc_wr && (misc_idx == i[4:0])) begin
                    misc_q[i] <= misc_data;
                end else if (clr_all || (motion_accept && (i <= 11))) begin
                    misc_q[i] <= `TSB_BYTE_RST;
                end
            end
            if (misc_wr && (misc_idx == `TSB_OFS_F17)) begin
                f17_q <= misc_data;
            end else if (clr_all) begin
                f17_q <= `TSB_BYTE_RST;
            end
        end
    end

    // ****************************************************************
    // Configuration-derived bytes
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            load_q                <= 1'b1;
            density_status_byte_q <= `TSB_BYTE_RST;
            config_status_byte_q  <= `TSB_BYTE_RST;
            condensed_last_byte_q <= `TSB_BYTE_RST;
        end else if (load_q) begin
            load_q                <= 1'b0;
            density_status_byte_q <= cfg_density_byte;
            config_status_byte_q  <= cfg_config_byte;
            condensed_last_byte_q <= cfg_density_byte;
        end else if (clr_all) begin
            density_status_byte_q <= {6'h00, density_sel};
            config_status_byte_q  <= `TSB_BYTE_RST;
            condensed_last_byte_q <= {6'h00, density_sel};
        end
    end

    // ****************************************************************
    // Byte selection for read-out
    // ****************************************************************
    always @* begin
        byte_d = `TSB_BYTE_RST;
        if (cond_q && (idx_q == `TSB_OFS_COND_LAST)) begin
            byte_d = condensed_last_byte_q;
        end else begin
            case (idx_q)
                `TSB_OFS_WR_ERR:    byte_d = write_error_count;
                `TSB_OFS_RD_ERR:    byte_d = read_hard_error_count;
                `TSB_OFS_DIAG_LOG:  byte_d = diag_program_log_q;
                `TSB_OFS_DIAG_FAIL: byte_d = diag_failure_code_q;
                `TSB_OFS_TRK_ERR:   byte_d = track_error_flags_q;
                `TSB_OFS_DETAIL:    byte_d = hard_error_detail;
                `TSB_OFS_DENSITY:   byte_d = density_status_byte_q;
                `TSB_OFS_CONFIG:    byte_d = config_status_byte_q;
                `TSB_OFS_F17:       byte_d = f17_q;
                5'd6, 5'd7, 5'd8, 5'd9, 5'd10, 5'd11, 5'd12, 5'd13: begin
                    byte_d = misc_q[idx_q];
                end
                default:            byte_d = `TSB_BYTE_RST;
            endcase
        end
    end

    // ****************************************************************
    // Read-out sequencer: one byte per clock from the first byte
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q    <= ST_IDLE;
            cond_q     <= 1'b0;
            idx_q      <= 5'h00;
            len_q      <= 5'h00;
            busy_q     <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
            rd_last_q  <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            rd_last_q  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_SEND;
                        cond_q  <= cmd_cond_status && !cmd_full_status && !cmd_diag_results;
                        len_q   <= (cmd_cond_status && !cmd_full_status && !cmd_diag_results) ?
                                   `TSB_COND_LEN : `TSB_FULL_LEN;
                        idx_q   <= 5'h00;
                        busy_q  <= 1'b1;
                    end
                end
                ST_SEND: begin
                    rd_valid_q <= 1'b1;
                    rd_data_q  <= byte_d;
                    if (idx_q == len_q - 5'h01) begin
                        rd_last_q <= 1'b1;
                        state_q   <= ST_IDLE;
                        busy_q    <= 1'b0;
                    end else begin
                        idx_q <= idx_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end
endmodule // tsb_status_bank

`default_nettype wire

// *** tsb_status_bank_sva.sv ***
// Port-level checks of the status bank read-out and hard error line.
// Bound to tsb_status_bank; sees only its ports, one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module tsb_status_bank_sva (
    input wire logic clk_sys,           // System clock
    input wire logic sys_rst,           // Synchronous reset
    input wire logic cmd_full_status,   // Full request
    input wire logic cmd_cond_status,   // Condensed request
    input wire logic cmd_diag_results,  // Diagnostics request
    input wire logic rd_hard_evt,       // Hard read error
    input wire logic rd_valid_q,        // Byte strobe
    input wire logic rd_last_q,         // Last byte
    input wire logic busy_q,            // Read-out busy
    input wire logic hard_error_line_q  // Hard error line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_start_delay: assert property ((cmd_full_status || cmd_cond_status || cmd_diag_results) && !busy_q
        && !$past(sys_rst) |=> busy_q && !rd_valid_q ##1 rd_valid_q) else $error("read-out start late");
    a_full_len: assert property ((cmd_full_status || cmd_diag_results) && !busy_q && !$past(sys_rst) |->
        ##2 (rd_valid_q && !rd_last_q)[*8] ##1 (rd_valid_q && !rd_last_q)[*8] ##1 (rd_valid_q && rd_last_q))
        else $error("full block length wrong");
    a_cond_len: assert property (cmd_cond_status && !cmd_full_status && !cmd_diag_results && !busy_q
        && !$past(sys_rst) |-> ##2 (rd_valid_q && !rd_last_q)[*8] ##1 (rd_valid_q && rd_last_q))
        else $error("condensed block length wrong");
    a_byte_stream: assert property (rd_valid_q && !rd_last_q |=> rd_valid_q) else $error("gap in block");
    a_after_last: assert property (rd_last_q |=> !rd_valid_q) else $error("byte after last");
    a_last_idle: assert property (rd_last_q |-> rd_valid_q && !busy_q) else $error("busy with last byte");
    a_herr_cause: assert property (hard_error_line_q |-> $past(rd_hard_evt)) else $error("stray hard line");
    a_herr_pulse: assert property (rd_hard_evt |=> hard_error_line_q) else $error("hard line missing");
    a_reset_out: assert property ($fell(sys_rst) |-> !busy_q && !rd_valid_q && !hard_error_line_q)
        else $error("outputs active after reset");
endmodule // tsb_status_bank_sva
bind tsb_status_bank tsb_status_bank_sva chk_u (.clk_sys, .sys_rst, .cmd_full_status, .cmd_cond_status,
    .cmd_diag_results, .rd_hard_evt, .rd_valid_q, .rd_last_q, .busy_q, .hard_error_line_q);
`default_nettype wire

// *** tsb_host_model.sv ***
// Host tape controller model: issues status access commands, gathers bytes.
// Assumes the bank's pulse request and byte stream on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tsb_host_model (
    input  wire logic       clk_sys,          // System clock
    input  wire logic       rd_valid_q,       // Byte strobe
    input  wire logic [7:0] rd_data_q,        // Returned byte
    input  wire logic       rd_last_q,        // Last byte of block
    output var  logic       cmd_full_status,  // Full request
    output var  logic       cmd_cond_status,  // Condensed request
    output var  logic       cmd_diag_results  // Diagnostics request
);
    logic [7:0] blk [0:16];
    int         n = 0;
    initial {cmd_full_status, cmd_cond_status, cmd_diag_results} = 3'h0;
    // Kind 0 full, 1 condensed, 2 diagnostic results; one-cycle request
    task automatic read_block(input int kind);
        n = 0;
        @(posedge clk_sys);
        cmd_full_status  <= (kind == 0);
        cmd_cond_status  <= (kind == 1);
        cmd_diag_results <= (kind == 2);
        @(posedge clk_sys);
        {cmd_full_status, cmd_cond_status, cmd_diag_results} <= 3'h0;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            if (rd_valid_q && n < 17) begin
                blk[n] = rd_data_q;
                n++;
                if (rd_last_q) return;
            end
        end
    endtask
endmodule // tsb_host_model
`default_nettype wire

// *** tsb_status_bank_test.sv ***
// Self-checking bench of the status byte bank with a host model.
// Assumes tsb_status_bank, tsb_host_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tsb_status_bank_test;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, online = 1'b0, failure_skip = 1'b0, diag_from_panel = 1'b0;
    logic [16:0] ev = 17'h0;
    logic [7:0]  cfg_density_byte = 8'h5a, cfg_config_byte = 8'hc3, diag_code = 8'h00, trk_err_mask = 8'h00;
    logic [7:0]  misc_data = 8'h00;
    logic [6:0]  diag_num = 7'h00;
    logic [4:0]  misc_idx = 5'h00;
    logic [3:0]  skew_bits = 4'h0, drop_trk_cnt = 4'h0;
    logic [1:0]  density_sel = 2'h1;
    wire logic   cmd_full_status, cmd_cond_status, cmd_diag_results, rd_valid_q, rd_last_q, busy_q, hard_error_line_q;
    logic        rd_fwd_fmt = 1'b1, single_drop = 1'b0;
    wire logic [7:0] rd_data_q;
    logic [7:0]  ex [0:16];
    int          errors = 0, compares = 0;
    tsb_status_bank dut_u (
        .clk_sys, .sys_rst, .cfg_density_byte, .cfg_config_byte, .density_sel, .online, .failure_skip,
        .cmd_full_status, .cmd_cond_status, .cmd_diag_results, .motion_accept(ev[14]), .diag_clear(ev[15]),
        .wr_err_evt(ev[0]), .rd_hard_evt(ev[1]), .diag_call(ev[2]), .diag_from_panel, .diag_num,
        .diag_fail(ev[3]), .diag_code, .trk_err_evt(ev[4]), .trk_err_mask, .ident_evt(ev[5]),
        .rd_fwd_fmt, .corr_evt(ev[6]), .vpe_evt(ev[7]), .single_drop, .skew_bits,
        .skew_evt(ev[8]), .drop_evt(ev[9]), .drop_trk_cnt, .fpost_evt(ev[10]), .fpre_evt(ev[11]),
        .lrc_evt(ev[12]), .crc_evt(ev[13]), .misc_wr(ev[16]), .misc_idx, .misc_data,
        .rd_valid_q, .rd_data_q, .rd_last_q, .busy_q, .hard_error_line_q);
    tsb_host_model host_u (.clk_sys, .rd_valid_q, .rd_data_q, .rd_last_q, .cmd_full_status,
        .cmd_cond_status, .cmd_diag_results);
    initial forever #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One-cycle pulse on event line k
    task automatic fire(input int k);
        @(posedge clk_sys);
        ev <= 17'h1 << k;
        @(posedge clk_sys);
        ev <= 17'h0;
    endtask
    // Read a block and compare its length and every byte with the shadow
    task automatic rd(input int kind);
        host_u.read_block(kind);
        chk(8'(host_u.n), (kind == 1) ? 8'h09 : 8'h11);
        for (int i = 0; i < host_u.n; i++) chk(host_u.blk[i], (kind == 1 && i == 8) ? ex[14] : ex[i]);
    endtask
    // Motion clear, then one detail event under density d
    task automatic det(input logic [1:0] d, input int k, input logic [3:0] s, input logic [7:0] e);
        @(posedge clk_sys);
        density_sel <= d;
        skew_bits <= s;
        drop_trk_cnt <= s;
        fire(14);
        fire(k);
        ex[5] = e;
        rd(0);
    endtask
    initial begin
        #200us;
        errors++;
        give_verdict;
    end
    initial begin
        ex = '{default: 8'h00};
        ex[14] = cfg_density_byte;
        ex[15] = cfg_config_byte;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(0);
        rd(1);
        @(posedge clk_sys);
        online <= 1'b1;
        repeat (3) fire(0);
        repeat (2) fire(1);
        @(posedge clk_sys);
        online <= 1'b0;
        fire(1);
        ex[0] = 8'h03;
        ex[1] = 8'h02;
        rd(2);
        @(posedge clk_sys);
        online <= 1'b1;
        repeat (300) fire(0);
        ex[0] = 8'hff;
        rd(0);
        @(posedge clk_sys);
        diag_num <= 7'h7f;
        diag_code <= 8'h5a;
        fire(2);
        fire(3);
        ex[2] = 8'h1f;
        ex[3] = 8'h5a;
        rd(0);
        @(posedge clk_sys);
        diag_from_panel <= 1'b1;
        diag_num <= 7'h45;
        fire(2);
        ex[2] = 8'h45;
        ex[3] = 8'h00;
        rd(0);
        @(posedge clk_sys);
        trk_err_mask <= 8'h81;
        misc_idx <= 5'h06;
        misc_data <= 8'h3c;
        fire(4);
        fire(16);
        @(posedge clk_sys);
        trk_err_mask <= 8'h04;
        misc_idx <= 5'h0c;
        misc_data <= 8'ha5;
        fire(4);
        fire(16);
        ex[4] = 8'h85;
        ex[6] = 8'h3c;
        ex[12] = 8'ha5;
        rd(0);
        fire(14);
        ex[4] = 8'h00;
        ex[6] = 8'h00;
        rd(0);
        det(2'h0, 12, 4'h0, 8'h84);
        det(2'h0, 13, 4'h0, 8'h82);
        det(2'h0, 7, 4'h0, 8'h81);
        det(2'h0, 8, 4'h9, 8'h80);
        det(2'h2, 5, 4'h0, 8'h40);
        det(2'h2, 6, 4'h0, 8'h20);
        det(2'h2, 7, 4'h0, 8'h10);
        det(2'h2, 8, 4'h9, 8'h08);
        det(2'h2, 8, 4'h8, 8'h00);
        det(2'h2, 9, 4'h2, 8'h00);
        det(2'h2, 9, 4'h3, 8'h04);
        det(2'h2, 10, 4'h0, 8'h02);
        det(2'h2, 11, 4'h0, 8'h01);
        det(2'h1, 11, 4'h0, 8'h03);
        det(2'h1, 9, 4'h2, 8'h04);
        @(posedge clk_sys);
        density_sel <= 2'h2;
        failure_skip <= 1'b1;
        online <= 1'b0;
        diag_code <= 8'h77;
        rd_fwd_fmt <= 1'b0;
        single_drop <= 1'b1;
        det(2'h2, 5, 4'h0, 8'h00);
        det(2'h2, 7, 4'h0, 8'h00);
        fire(15);
        fire(3);
        fire(3);
        ex = '{default: 8'h00};
        ex[14] = 8'h02;
        ex[3] = 8'h02;
        rd(0);
        rd(1);
        give_verdict;
    end
endmodule // tsb_status_bank_test
`default_nettype wire
